// File: rtl/sacoi_pkg.sv
// Package: shared constants and carrier types for the converter output block.
// Assumes: used by sacoi_top, sacoi_serializer and the verification files.
package sacoi_pkg;

  // Result width and serial frame
  localparam int RES_W        = 14;
  localparam int FRAME_BITS   = 16;
  localparam int LEAD_ZEROS   = 2;
  localparam int LSB_DIVISOR  = 16384;  // Full scale / 16384 per code

  // Conversion length in ADC clock rising edges
  localparam int CONV_EDGES_MIN = 19;
  localparam int CONV_EDGES_MAX = 20;

  // Start-to-edge window that forces the long conversion
  localparam int    START_WIN_NS  = 30;
  localparam int    CORE_CLK_HZ   = 10000000;
  localparam int    CORE_PER_NS   = 1000000000 / CORE_CLK_HZ;
  // Least time: round up, never below one cycle
  localparam int    START_WIN_CYC = ((START_WIN_NS + CORE_PER_NS - 1) /
                                     CORE_PER_NS) < 1 ? 1 :
                                    ((START_WIN_NS + CORE_PER_NS - 1) /
                                     CORE_PER_NS);

  // Byte format
  localparam int BYTE_W     = 8;
  localparam int HI_BITS    = 6;

  // Reset values
  localparam logic [13:0] RESULT_RST = 14'h0000;
  localparam logic [4:0]  EDGE_RST   = 5'h00;

  // Format pin decode: high = parallel, low = serial/byte
  typedef enum logic [1:0] {
    SACOI_FMT_PAR14  = 2'b00,
    SACOI_FMT_GATED  = 2'b01,  // 0 V: serial clock gated after frame
    SACOI_FMT_CONT   = 2'b10   // -5 V: serial clock runs free
  } sacoi_fmt_t;

  typedef enum logic [1:0] {
    SACOI_ST_IDLE = 2'b00,
    SACOI_ST_CONV = 2'b01,
    SACOI_ST_DONE = 2'b10
  } sacoi_state_t;

  // Open-drain pin: output level and enable
  typedef struct packed {
    logic o;
    logic oe;
  } sacoi_od_t;

  // Serial pins grouped together
  typedef struct packed {
    sacoi_od_t strobe_n;
    sacoi_od_t sclk;
    sacoi_od_t serial_out;
  } sacoi_ser_t;

endpackage

// File: rtl/sacoi_serializer.sv
// Serial frame shifter on the ADC clock domain.
// Assumes: start_tgl_in toggles once per frame and the word is stable
// while the toggle crosses; adc_clk_in runs continuously.
`timescale 1ns/1ps
module sacoi_serializer (
  // Link clock and reset
  input  wire logic                         adc_clk_in,
  input  wire logic                         rst_b_in,
  // Frame request from core domain
  input  wire logic                         start_tgl_in,
  input  wire logic [sacoi_pkg::RES_W-1:0]  word_in,
  input  wire logic                         enable_in,
  input  wire logic                         cont_in,
  // Serial pins
  output sacoi_pkg::sacoi_ser_t             ser_out
);

  logic       tgl_s;
  logic       tgl_d_q;
  logic       active_q;
  logic [4:0] cnt_q;
  logic [15:0] sh_q;
  logic       sclk_q;
  logic       en_s;
  logic       cont_s;

  sacoi_sync2 #(.W(3)) u_sync (
    .clk_in   (adc_clk_in),
    .rst_b_in (rst_b_in),
    .d_in     ({start_tgl_in, enable_in, cont_in}),
    .q_out    ({tgl_s, en_s, cont_s})
  );

  // Frame control: 16 bits, two zeros then result MSB first
  always_ff @(posedge adc_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tgl_d_q  <= 1'b0;
      active_q <= 1'b0;
      cnt_q    <= 5'h00;
      sh_q     <= 16'h0000;
    end else begin
      if (!en_s) begin
        // Requests met while the serial pins are off are dropped
        tgl_d_q <= tgl_s;
      end else if (tgl_s != tgl_d_q && !sclk_q) begin
        // Start only as the clock rises: no fall meets the strobe edge,
        // and the first fall shows the first leading zero
        tgl_d_q  <= tgl_s;
        active_q <= 1'b1;
        cnt_q    <= 5'h00;
        sh_q     <= {2'b00, word_in};
      end else if (active_q && !sclk_q) begin
        // Data moves as the clock rises, half a period from the sample
        sh_q  <= {sh_q[14:0], 1'b0};
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q == 5'(sacoi_pkg::FRAME_BITS - 1)) begin
          active_q <= 1'b0;
        end
      end
    end
  end

  // Serial clock at half the ADC clock, derived from it
  always_ff @(posedge adc_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= ~sclk_q;
    end
  end

  // Open-drain: only pull low, never drive high
  always_comb begin
    ser_out.strobe_n.o  = 1'b0;
    ser_out.strobe_n.oe = active_q;
    ser_out.serial_out.o     = 1'b0;
    ser_out.serial_out.oe    = active_q && !sh_q[15];
    ser_out.sclk.o      = 1'b0;
    // Gated clock released after frame unless continuous
    ser_out.sclk.oe     = en_s && !sclk_q &&
                          (active_q || cont_s);
  end

endmodule

// File: rtl/sacoi_sync2.sv
// Two-flop level synchroniser.
// Assumes: d_in is asynchronous to clk_in; q_out only feeds logic.
`timescale 1ns/1ps
module sacoi_sync2 #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0  // Idle level shown during reset
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_q;

  // First flop feeds only the second one
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= RST_VAL;
      q_out  <= RST_VAL;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end

endmodule

// File: rtl/sacoi_top.sv
// Top: conversion control, track/hold, flag and parallel/byte output.
// Assumes: pins are asynchronous and are synchronised here; the analog
// SAR supplies its result on sar_result_in at end of conversion.
// Contract
// - conversion lasts 19 or 20 ADC edges
// - start near clock edge takes 20 edges; code takes 20 whenever adc_q is low
// - pulse mode holds on start rising edge
// - chip-select mode holds on select falling edge
// - track/hold returns to track at end
// - host mode: select plus read start, flag waits
// - serial-only variant uses pulse start only
// - format high gives 14-bit parallel only
// - format low gives serial and byte output
// - top data pins become select and serial
// - parallel drives all 14 bits MSB on 13
// - byte reads: low eight, upper six justified
// - serial frame is two zeros, result MSB-first
// - data changes on rising serial clock edge
// - strobe low at start, first zero valid
// - serial clock derived from master clock
// - format pin picks continuous or gated clock
// - serial-only control pin gates serial clock
// - serial lines are open-drain pull-low only
// - result is 14-bit two's complement code
// - any format works in either start mode
// - pulse mode flag is interrupt, read clears
// - host mode flag is busy during conversion
`timescale 1ns/1ps
module sacoi_top #(
  parameter bit SERIAL_ONLY = 1'b0
) (
  // Core clock and reset
  input  wire logic                         core_clk_in,
  input  wire logic                         rst_b_in,
  // ADC master clock (internal or external source)
  input  wire logic                         adc_clk_in,
  // Host control pins
  input  wire logic                         convert_start_n_in,
  input  wire logic                         chip_select_n_in,
  input  wire logic                         read_n_in,
  input  wire logic                         format_high_in,
  input  wire logic                         format_neg_in,
  input  wire logic                         clock_control_neg_in,
  // Analog core result
  input  wire logic [sacoi_pkg::RES_W-1:0]  sar_result_in,
  // Status outputs
  output logic                              track_hold_out,
  output logic                              conv_flag_n_out,
  // Data bus: data_bit_13 doubles as high_byte_select input
  input  wire logic                         high_byte_select_in,
  output logic [sacoi_pkg::RES_W-1:0]       data_out,
  output logic [sacoi_pkg::RES_W-1:0]       data_oe_out,
  // Serial open-drain pins
  output sacoi_pkg::sacoi_ser_t             ser_out
);

  // Synchronised pins
  logic        cst_s;
  logic        cs_s;
  logic        rd_s;
  logic        fhi_s;
  logic        fneg_s;
  logic        cneg_s;
  logic        hbs_s;
  logic        adc_s;
  logic        cst_q;
  logic        cs_q;
  logic        rdsel_q;
  logic        adc_q;

  // Active-low pins reset to their idle high level: no false edge
  sacoi_sync2 #(.W(8), .RST_VAL(8'he0)) u_pin_sync (
    .clk_in   (core_clk_in),
    .rst_b_in (rst_b_in),
    .d_in     ({convert_start_n_in, chip_select_n_in, read_n_in,
                format_high_in, format_neg_in, clock_control_neg_in,
                high_byte_select_in, adc_clk_in}),
    .q_out    ({cst_s, cs_s, rd_s, fhi_s, fneg_s, cneg_s, hbs_s, adc_s})
  );

  // Edge history of synchronised pins
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cst_q   <= 1'b1;
      cs_q    <= 1'b1;
      rdsel_q <= 1'b1;
      adc_q   <= 1'b0;
    end else begin
      cst_q   <= cst_s;
      cs_q    <= cs_s;
      rdsel_q <= cs_s | rd_s;
      adc_q   <= adc_s;
    end
  end

  // Format and mode decode
  sacoi_pkg::sacoi_fmt_t fmt;
  logic host_mode;
  logic cst_rise;
  logic cs_fall;
  logic rdsel_fall;
  logic start;

  always_comb begin
    if (fhi_s && !SERIAL_ONLY) begin
      fmt = sacoi_pkg::SACOI_FMT_PAR14;
    end else if (SERIAL_ONLY ? cneg_s : fneg_s) begin
      fmt = sacoi_pkg::SACOI_FMT_CONT;
    end else begin
      fmt = sacoi_pkg::SACOI_FMT_GATED;
    end
  end

  // Host mode while start pin held low; never on serial-only part
  assign host_mode  = !SERIAL_ONLY && !cst_s;
  assign cst_rise   = cst_s && !cst_q;
  assign cs_fall    = !cs_s && cs_q;
  assign rdsel_fall = !(cs_s | rd_s) && rdsel_q;

  sacoi_pkg::sacoi_state_t state_q;
  logic [4:0]              need_q;
  logic                    done;
  logic                    done_tgl_s;
  logic                    done_seen_q;

  // Host mode: chip select falling with read low starts conversion; byte select low needed outside parallel
  assign start = (state_q != sacoi_pkg::SACOI_ST_CONV) &&
                 (host_mode ? (cs_fall && !rd_s &&
                               (fmt == sacoi_pkg::SACOI_FMT_PAR14 ||
                                !hbs_s))
                            : cst_rise);

  assign done = (state_q == sacoi_pkg::SACOI_ST_CONV) &&
                (done_tgl_s != done_seen_q);

  // Conversion sequencer; the ADC edges are counted on the ADC clock
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= sacoi_pkg::SACOI_ST_IDLE;
      need_q  <= 5'(sacoi_pkg::CONV_EDGES_MIN);
    end else begin
      case (state_q)
        sacoi_pkg::SACOI_ST_IDLE,
        sacoi_pkg::SACOI_ST_DONE: begin
          if (start) begin
            state_q <= sacoi_pkg::SACOI_ST_CONV;
            // A start while the delayed ADC clock sample adc_q is low costs the full 20
            need_q  <= (adc_s && !adc_q) || (!adc_s && !adc_q) ?
                       5'(sacoi_pkg::CONV_EDGES_MAX) :
                       5'(sacoi_pkg::CONV_EDGES_MIN);
          end
        end
        sacoi_pkg::SACOI_ST_CONV: begin
          if (done) begin
            state_q <= sacoi_pkg::SACOI_ST_DONE;
          end
        end
        default: begin
          state_q <= sacoi_pkg::SACOI_ST_IDLE;
        end
      endcase
    end
  end

  // Track/hold: high while holding
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      track_hold_out <= 1'b0;
    end else if (start) begin
      track_hold_out <= 1'b1;
    end else if (done) begin
      track_hold_out <= 1'b0;
    end
  end

  // Result register, two's complement as delivered by the SAR
  logic [sacoi_pkg::RES_W-1:0] result_q;
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      result_q <= sacoi_pkg::RESULT_RST;
    end else if (done) begin
      result_q <= sar_result_in;
    end
  end

  // Flag: busy in host mode, interrupt in pulse mode.
  // End of conversion wins over a read arriving in the same cycle.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      conv_flag_n_out <= 1'b1;
    end else if (host_mode) begin
      if (start) begin
        conv_flag_n_out <= 1'b0;
      end else if (done) begin
        conv_flag_n_out <= 1'b1;
      end
    end else if (done) begin
      conv_flag_n_out <= 1'b0;
    end else if (rdsel_fall) begin
      conv_flag_n_out <= 1'b1;
    end
  end

  // Parallel and byte drive while selected and reading
  logic reading;
  assign reading = !cs_s && !rd_s && !SERIAL_ONLY;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_out    <= 14'h0000;
      data_oe_out <= 14'h0000;
    end else if (fmt == sacoi_pkg::SACOI_FMT_PAR14) begin
      data_out    <= result_q;
      data_oe_out <= {14{reading}};
    end else begin
      // Top four pins belong to byte select and serial lines
      data_out    <= {6'h00, hbs_s ?
                      {2'b00, result_q[13:8]} :
                      result_q[7:0]};
      data_oe_out <= {6'h00, {8{reading}}};
    end
  end

  // Frame request toggle into the ADC clock domain
  logic start_tgl_q;
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      start_tgl_q <= 1'b0;
    end else if (start) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  // Conversion request crosses to the ADC clock as a toggle
  logic       conv_tgl_s;
  logic       conv_seen_q;
  logic       conv_run_q;
  logic [4:0] adc_edges_q;
  logic       done_tgl_q;

  sacoi_sync2 #(.W(1)) u_conv_sync (
    .clk_in   (adc_clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (start_tgl_q),
    .q_out    (conv_tgl_s)
  );

  // Count real ADC rising edges; need_q was set with the toggle and
  // holds still until done returns, so it is read here without a sync
  always_ff @(posedge adc_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      conv_seen_q <= 1'b0;
      conv_run_q  <= 1'b0;
      adc_edges_q <= sacoi_pkg::EDGE_RST;
      done_tgl_q  <= 1'b0;
    end else if (conv_tgl_s != conv_seen_q) begin
      conv_seen_q <= conv_tgl_s;
      conv_run_q  <= 1'b1;
      adc_edges_q <= 5'h01;
    end else if (conv_run_q) begin
      adc_edges_q <= adc_edges_q + 5'h01;
      if (adc_edges_q + 5'h01 == need_q) begin
        conv_run_q <= 1'b0;
        done_tgl_q <= ~done_tgl_q;
      end
    end
  end

  // End of conversion returns to the core clock as a toggle
  sacoi_sync2 #(.W(1)) u_done_sync (
    .clk_in   (core_clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (done_tgl_q),
    .q_out    (done_tgl_s)
  );

  // Last done toggle taken by the core
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      done_seen_q <= 1'b0;
    end else begin
      done_seen_q <= done_tgl_s;
    end
  end

  // Serial result is the previous conversion, stable during the frame
  sacoi_serializer u_ser (
    .adc_clk_in   (adc_clk_in),
    .rst_b_in     (rst_b_in),
    .start_tgl_in (start_tgl_q),
    .word_in      (result_q),
    .enable_in    (fmt != sacoi_pkg::SACOI_FMT_PAR14),
    .cont_in      (fmt == sacoi_pkg::SACOI_FMT_CONT),
    .ser_out      (ser_out)
  );

endmodule

// File: verification/sacoi_host_model.sv
// Serial receiver on the far side of the open-drain lines.
// Assumes: pull-ups on every line; frame restarts at strobe fall.
`timescale 1ns/1ps
module sacoi_host_model (
  // Open-drain lines
  input  wire sacoi_pkg::sacoi_ser_t ser_in,
  // Captured frame and counts
  output logic [15:0]                frame_out,
  output int                         bits_out,
  output int                         idle_out
);
  // Released lines float up to the pull-up level
  wire strobe_w = ser_in.strobe_n.oe ? ser_in.strobe_n.o : 1'b1;
  wire sclk_w   = ser_in.sclk.oe ? ser_in.sclk.o : 1'b1;
  wire serial_out_w  = ser_in.serial_out.oe ? ser_in.serial_out.o : 1'b1;

  initial begin
    frame_out = 16'h0000;
    bits_out  = 0;
    idle_out  = 0;
  end

  // New frame: counts restart
  always @(negedge strobe_w) begin
    bits_out = 0;
    idle_out = 0;
  end

  // Sample on falling clock while framed, else count idle edges
  always @(negedge sclk_w) begin
    if (!strobe_w && bits_out < 16) begin
      frame_out = {frame_out[14:0], serial_out_w};
      bits_out++;
    end else if (strobe_w) begin
      idle_out++;
    end
  end
endmodule

// File: verification/sacoi_top_assertions.sv
// Checker: port relations of the converter output block.
// Assumes: bound to sacoi_top; all checks on the core clock.
`timescale 1ns/1ps
module sacoi_top_assertions (
  // Clock and reset
  input wire logic                  core_clk_in,
  input wire logic                  adc_clk_in,
  input wire logic                  rst_b_in,
  // Pins watched
  input wire logic                  convert_start_n_in,
  input wire logic                  chip_select_n_in,
  input wire logic                  format_high_in,
  input wire logic                  track_hold_out,
  input wire logic                  conv_flag_n_out,
  input wire logic [13:0]           data_oe_out,
  input wire sacoi_pkg::sacoi_ser_t ser_out
);
  logic [7:0] hold_adc_q;
  logic       th_adc_q;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  // ADC edges spent in hold; kept after release for the length check
  always_ff @(posedge adc_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      th_adc_q   <= 1'b0;
      hold_adc_q <= 8'h00;
    end else begin
      th_adc_q <= track_hold_out;
      if (track_hold_out && !th_adc_q) begin
        hold_adc_q <= 8'h01;
      end else if (track_hold_out && hold_adc_q != 8'hff) begin
        hold_adc_q <= hold_adc_q + 8'h01;
      end
    end
  end

  sequence s_start;
    $rose(track_hold_out);
  endsequence
  sequence s_back;
    ##[1:1000] !track_hold_out;
  endsequence

  property p_end;
    s_start |-> s_back;
  endproperty
  a_end: assert property (p_end)
    else $error("hold never released");
  // At least 19 ADC edges; the top bound covers both crossings
  property p_len;
    $fell(track_hold_out) |-> hold_adc_q >= 8'h13 && hold_adc_q <= 8'h78;
  endproperty
  a_len: assert property (p_len)
    else $error("conversion too short");
  property p_busy;
    s_start and !convert_start_n_in |-> !conv_flag_n_out;
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy not low at start");
  property p_irq;
    !conv_flag_n_out && convert_start_n_in && chip_select_n_in &&
    $past(chip_select_n_in) && $past(chip_select_n_in, 2)
    |=> !conv_flag_n_out;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt cleared without read");
  property p_par;
    format_high_in && $past(format_high_in, 4) && data_oe_out != 14'h0
    |-> data_oe_out == 14'h3fff;
  endproperty
  a_par: assert property (p_par)
    else $error("parallel word not driven whole");
  property p_park;
    format_high_in && $past(format_high_in, 8)
    |-> !(ser_out.strobe_n.oe | ser_out.sclk.oe | ser_out.serial_out.oe);
  endproperty
  a_park: assert property (p_park)
    else $error("serial line active in parallel format");
  property p_pins;
    !format_high_in && !$past(format_high_in, 4)
    |-> data_oe_out[13:10] == 4'h0;
  endproperty
  a_pins: assert property (p_pins)
    else $error("shared pin driven as data");
  property p_od;
    ser_out.strobe_n.oe | ser_out.sclk.oe | ser_out.serial_out.oe
    |-> {ser_out.strobe_n.o, ser_out.sclk.o, ser_out.serial_out.o} == 3'h0;
  endproperty
  a_od: assert property (p_od)
    else $error("serial line driven high");
endmodule

bind sacoi_top sacoi_top_assertions sacoi_top_assertions_i (
  .core_clk_in        (core_clk_in),
  .adc_clk_in         (adc_clk_in),
  .rst_b_in           (rst_b_in),
  .convert_start_n_in (convert_start_n_in),
  .chip_select_n_in   (chip_select_n_in),
  .format_high_in     (format_high_in),
  .track_hold_out     (track_hold_out),
  .conv_flag_n_out    (conv_flag_n_out),
  .data_oe_out        (data_oe_out),
  .ser_out            (ser_out)
);

// File: verification/sacoi_top_tb_top.sv
// Bench: pulse and host starts over parallel, byte and serial formats.
// Assumes: sacoi_top with the host model on its serial lines.
`timescale 1ns/1ps
module sacoi_top_tb_top;
  logic                  core_clk_in = 1'b0;
  logic                  adc_clk     = 1'b0;
  logic                  rst_b       = 1'b0;
  logic                  start_n     = 1'b1;
  logic                  cs_n        = 1'b1;
  logic                  rd_n        = 1'b1;
  logic                  fmt_hi      = 1'b1;
  logic                  fmt_neg     = 1'b0;
  logic                  hbs         = 1'b0;
  logic [13:0]           sar         = 14'h0000;
  logic                  th;
  logic                  flag_n;
  logic [13:0]           dout;
  logic [13:0]           doe;
  logic [13:0]           val;
  logic [15:0]           frame;
  sacoi_pkg::sacoi_ser_t ser;
  int                    bits;
  int                    idle;
  int                    fail_count  = 0;
  int                    checks_done = 0;
  int                    cyc         = 0;

  initial forever #50 core_clk_in = ~core_clk_in;
  // Link clock, phase unrelated to the core clock
  initial begin
    #1.7;
    forever #3 adc_clk = ~adc_clk;
  end

  sacoi_top sacoi_top_i (
    .core_clk_in          (core_clk_in),
    .rst_b_in             (rst_b),
    .adc_clk_in           (adc_clk),
    .convert_start_n_in   (start_n),
    .chip_select_n_in     (cs_n),
    .read_n_in            (rd_n),
    .format_high_in       (fmt_hi),
    .format_neg_in        (fmt_neg),
    .clock_control_neg_in (1'b0),
    .sar_result_in        (sar),
    .track_hold_out       (th),
    .conv_flag_n_out      (flag_n),
    .high_byte_select_in  (hbs),
    .data_out             (dout),
    .data_oe_out          (doe),
    .ser_out              (ser)
  );
  sacoi_host_model sacoi_host_model_i (
    .ser_in    (ser),
    .frame_out (frame),
    .bits_out  (bits),
    .idle_out  (idle)
  );

  task automatic results();
    $display("Checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  // Bounded wait for the track/hold level
  task automatic wait_th(input logic v);
    for (int n = 0; n < 2000 && th !== v; n++) @(negedge core_clk_in);
    chk("track_hold", {15'h0, v}, {15'h0, th});
  endtask

  task automatic pulse(input logic [13:0] v);
    @(posedge core_clk_in);
    sar <= v;
    start_n <= 1'b0;
    repeat (4) @(negedge core_clk_in);
    chk("early_hold", 16'h0, {15'h0, th});
    @(posedge core_clk_in);
    start_n <= 1'b1;
    wait_th(1'b1);
    chk("flag_conv", 16'h1, {15'h0, flag_n});
    wait_th(1'b0);
    repeat (2) @(negedge core_clk_in);
    chk("flag_end", 16'h0, {15'h0, flag_n});
  endtask

  // Byte select settles before the read strobes fall
  task automatic rd(input logic hb, output logic [13:0] d);
    @(posedge core_clk_in);
    hbs <= hb;
    repeat (3) @(posedge core_clk_in);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    for (int n = 0; n < 2000 && doe === 14'h0; n++) @(negedge core_clk_in);
    d = dout;
    @(posedge core_clk_in);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (4) @(posedge core_clk_in);
  endtask

  task automatic frame_chk(input logic [13:0] v);
    for (int n = 0; n < 200 && bits < 16; n++) @(negedge core_clk_in);
    chk("frame", {2'b00, v}, frame);
  endtask

  // Cuts a hang short
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    repeat (6) @(posedge core_clk_in);
    rst_b <= 1'b1;
    repeat (3) @(negedge core_clk_in);
    chk("reset", 16'h4000, {th, flag_n, doe});
    pulse(14'h2a5c);
    rd(1'b0, val);
    chk("par_word", 16'h2a5c, {2'b00, val});
    chk("unipolar", 16'h0a5c, {2'b00, ~val[13], val[12:0]});
    chk("flag_read", 16'h1, {15'h0, flag_n});
    // Byte format, gated serial clock
    @(posedge core_clk_in);
    fmt_hi <= 1'b0;
    repeat (8) @(posedge core_clk_in);
    pulse(14'h1234);
    frame_chk(14'h2a5c);
    repeat (20) @(negedge core_clk_in);
    chk("gated_idle", 16'h0, idle[15:0]);
    rd(1'b0, val);
    chk("low_byte", 16'h0034, {8'h00, val[7:0]});
    rd(1'b1, val);
    chk("high_byte", 16'h0012, {8'h00, val[7:0]});
    // Host start, continuous serial clock
    @(posedge core_clk_in);
    fmt_neg <= 1'b1;
    start_n <= 1'b0;
    sar <= 14'h3ffe;
    hbs <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    wait_th(1'b1);
    chk("busy", 16'h0, {15'h0, flag_n});
    wait_th(1'b0);
    repeat (2) @(negedge core_clk_in);
    chk("busy_end", 16'h1, {15'h0, flag_n});
    for (int n = 0; n < 50 && doe === 14'h0; n++) @(negedge core_clk_in);
    chk("host_low", 16'h00fe, {8'h00, dout[7:0]});
    @(posedge core_clk_in);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    frame_chk(14'h1234);
    repeat (20) @(negedge core_clk_in);
    chk("cont_run", 16'h1, {15'h0, idle > 0});
    rd(1'b1, val);
    chk("host_high", 16'h003f, {8'h00, val[7:0]});
    results();
  end
endmodule
